//--- rtl/rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h0E;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0F;
  localparam logic [7:0] ADDR_CHARGE  = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_OSC_HALT_BIT  = 7;
  localparam int CTRL_BACKUP_EN_BIT = 5;
  localparam int CTRL_RATE_HI_BIT   = 4;
  localparam int CTRL_RATE_LO_BIT   = 3;
  localparam int CTRL_INT_MODE_BIT  = 2;
  localparam int CTRL_A2_IE_BIT     = 1;
  localparam int CTRL_A1_IE_BIT     = 0;
  localparam int FLAG_OSC_STOP_BIT  = 7;
  localparam int FLAG_ALARM_TWO_BIT = 1;
  localparam int FLAG_ALARM_ONE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and masks
  localparam logic [7:0] CONTROL_RESET      = 8'h18;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBF;
  localparam logic [7:0] FLAGS_RESET        = 8'h80;
  localparam logic [7:0] FLAGS_READ_MASK    = 8'h83;
  localparam logic [7:0] CHARGE_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Charger and rate encodings
  localparam logic [3:0] CHARGER_KEY_ON = 4'hA;
  localparam logic [1:0] DIODE_NONE     = 2'h1;
  localparam logic [1:0] DIODE_ONE      = 2'h2;
  localparam logic [1:0] RES_OFF        = 2'h0;
  localparam logic [1:0] RES_250        = 2'h1;
  localparam logic [1:0] RES_2K         = 2'h2;
  localparam logic [1:0] RES_4K         = 2'h3;
  localparam logic [1:0] RATE_1HZ       = 2'h0;
  localparam logic [1:0] RATE_4K        = 2'h1;
  localparam logic [1:0] RATE_8K        = 2'h2;
  localparam logic [1:0] RATE_32K       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS     = 8;
  localparam int OSC_STOP_TIME_NS  = 100000;
  localparam int OSC_STOP_CYCLES   = OSC_STOP_TIME_NS / CLK_PERIOD_NS;
  localparam int DIV_WIDTH         = 15;
  localparam int TAP_4K            = 2;
  localparam int TAP_8K            = 1;
  localparam int TAP_1HZ           = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic osc_halt;
    logic unused6;
    logic backup_output_enable;
    logic rate_select_hi;
    logic rate_select_lo;
    logic interrupt_mode;
    logic alarm_two_irq_enable;
    logic alarm_one_irq_enable;
  } control_t;

  typedef struct packed {
    logic [3:0] charger_key;
    logic [1:0] diode_select;
    logic [1:0] resistor_select;
  } charge_t;

  typedef struct packed {
    logic       enable;
    logic       one_diode;
    logic [1:0] resistor_select;
  } charge_path_t;

endpackage : rtc_ctrl_pkg

//--- rtl/osc_sampler.sv
`timescale 1ns/10ps
module osc_sampler #(
  parameter int STOP_CYCLES = rtc_ctrl_pkg::OSC_STOP_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic osc_clk,
  output logic      osc_level,
  output logic      osc_rise,
  output logic      stopped
);

  logic        sync_first;
  logic        level_prev;
  logic [23:0] idle_count;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops before anything looks at the oscillator
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_first <= 1'b0;
      osc_level  <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      sync_first <= osc_clk;
      osc_level  <= sync_first;
      level_prev <= osc_level;
    end
  end

  assign osc_rise = osc_level & ~level_prev;

  ////////////////////////////////////////////////////////////////////////////
  // No edge for the timeout means the crystal has died
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_count <= 24'h000000;
      stopped    <= 1'b0;
    end else if (osc_level != level_prev) begin
      idle_count <= 24'h000000;
      stopped    <= 1'b0;
    end else if (idle_count == STOP_CYCLES[23:0]) begin
      stopped    <= 1'b1;
    end else begin
      idle_count <= idle_count + 24'h000001;
    end
  end

endmodule : osc_sampler

//--- rtl/wave_divider.sv
`timescale 1ns/10ps
module wave_divider (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic       osc_rise,
  input  wire logic       osc_level,
  input  wire logic [1:0] rate,
  output logic            wave,
  output logic            second_tick
);

  localparam int W = rtc_ctrl_pkg::DIV_WIDTH;

  logic [W-1:0] count;
  logic         next_wave;

  ////////////////////////////////////////////////////////////////////////////
  // Divider only advances on real oscillator edges while running
  always_ff @(posedge clk) begin
    if (reset) begin
      count       <= '0;
      second_tick <= 1'b0;
    end else begin
      second_tick <= run & osc_rise & (&count);
      if (run && osc_rise) begin
        count <= count + 1'b1;
      end
    end
  end

  always_comb begin
    case (rate)
      rtc_ctrl_pkg::RATE_1HZ: next_wave = count[rtc_ctrl_pkg::TAP_1HZ];
      rtc_ctrl_pkg::RATE_4K:  next_wave = count[rtc_ctrl_pkg::TAP_4K];
      rtc_ctrl_pkg::RATE_8K:  next_wave = count[rtc_ctrl_pkg::TAP_8K];
      default:                next_wave = osc_level;
    endcase
  end

  // Halted oscillator freezes the wave at its last level
  always_ff @(posedge clk) begin
    if (reset) begin
      wave <= 1'b0;
    end else if (run) begin
      wave <= next_wave;
    end
  end

endmodule : wave_divider

//--- rtl/rtc_control_status_trickle.sv
`timescale 1ns/10ps
// Function
// - Halt bit stops oscillator, powers up zero
// - Backup enable keeps pin driven on battery
// - Rate codes pick 1Hz, 4k, 8k, 32k
// - Interrupt mode selects alarms over square wave
// - Alarm two drives pin when enabled
// - Alarm one drives pin; pin ORs both
// - Oscillator stop edge sets stop flag
// - Stop flag clears only by writing zero
// - Stop flag set at power-up and halt
// - Alarm two flag set on match, write-zero clears
// - Alarm one flag set on match, write-zero clears
// - Charger enabled only with key 1010
// - Diode codes 01 none, 10 one
// - Resistor codes 250, 2k, 4k; 00 off
// - Charger register resets to all zeros
// - Alarm matches evaluated once per second
// - Interrupt holds until flag is cleared
module rtc_control_status_trickle #(
  parameter int STOP_CYCLES = rtc_ctrl_pkg::OSC_STOP_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       osc_clk,
  input  wire logic                       on_backup,
  input  wire logic                       alarm_one_match,
  input  wire logic                       alarm_two_match,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_write,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_read,
  output logic [7:0]                      reg_rdata,
  output logic                            reg_rvalid,
  output logic                            osc_enable,
  output logic                            second_tick,
  output logic                            wave_irq_out,
  output logic                            wave_irq_oe_n,
  output logic                            irq_active,
  output rtc_ctrl_pkg::charge_path_t      charge_path
);

  rtc_ctrl_pkg::control_t control;
  rtc_ctrl_pkg::charge_t  charge_cfg;
  logic                   osc_stop_flag;
  logic                   alarm_two_flag;
  logic                   alarm_one_flag;
  logic                   osc_level;
  logic                   osc_rise;
  logic                   osc_dead;
  logic                   halt_prev;
  logic                   dead_prev;
  logic                   stop_event;
  logic                   wave;
  logic                   backup_sync1;
  logic                   backup_sync2;
  logic                   wr_control;
  logic                   wr_flags;
  logic                   wr_charge;
  logic                   next_irq;
  logic                   pin_release;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_control = reg_write & hit(reg_addr, rtc_ctrl_pkg::ADDR_CONTROL);
  assign wr_flags   = reg_write & hit(reg_addr, rtc_ctrl_pkg::ADDR_FLAGS);
  assign wr_charge  = reg_write & hit(reg_addr, rtc_ctrl_pkg::ADDR_CHARGE);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator sampling and division
  osc_sampler #(
    .STOP_CYCLES (STOP_CYCLES)
  ) u_sampler (
    .clk       (clk),
    .reset     (reset),
    .osc_clk   (osc_clk),
    .osc_level (osc_level),
    .osc_rise  (osc_rise),
    .stopped   (osc_dead)
  );

  wave_divider u_divider (
    .clk         (clk),
    .reset       (reset),
    .run         (osc_enable),
    .osc_rise    (osc_rise),
    .osc_level   (osc_level),
    .rate        ({control.rate_select_hi, control.rate_select_lo}),
    .wave        (wave),
    .second_tick (second_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk) begin
    if (reset) begin
      control <= rtc_ctrl_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control <= reg_wdata & rtc_ctrl_pkg::CONTROL_WRITE_MASK;
    end
  end

  assign osc_enable = ~control.osc_halt;

  ////////////////////////////////////////////////////////////////////////////
  // Stop flag: halt and a dead crystal each get their own edge, so halting
  // an already dead oscillator after a clear still records the stop
  assign stop_event = (control.osc_halt & ~halt_prev) |
                      (osc_dead & ~dead_prev);

  always_ff @(posedge clk) begin
    if (reset) begin
      halt_prev <= 1'b0;
      dead_prev <= 1'b0;
    end else begin
      halt_prev <= control.osc_halt;
      dead_prev <= osc_dead;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_stop_flag <= 1'b1;
    end else if (stop_event) begin
      osc_stop_flag <= 1'b1;
    end else if (wr_flags && !reg_wdata[rtc_ctrl_pkg::FLAG_OSC_STOP_BIT]) begin
      osc_stop_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm flags; a match in the clearing cycle still sets the flag
  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_two_flag <= 1'b0;
    end else if (second_tick && alarm_two_match) begin
      alarm_two_flag <= 1'b1;
    end else if (wr_flags && !reg_wdata[rtc_ctrl_pkg::FLAG_ALARM_TWO_BIT]) begin
      alarm_two_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_one_flag <= 1'b0;
    end else if (second_tick && alarm_one_match) begin
      alarm_one_flag <= 1'b1;
    end else if (wr_flags && !reg_wdata[rtc_ctrl_pkg::FLAG_ALARM_ONE_BIT]) begin
      alarm_one_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charger register and decode
  always_ff @(posedge clk) begin
    if (reset) begin
      charge_cfg <= rtc_ctrl_pkg::CHARGE_RESET;
    end else if (wr_charge) begin
      charge_cfg <= reg_wdata;
    end
  end

  // Only the documented diode codes pass; 00 and 11 both fail safe
  always_ff @(posedge clk) begin
    if (reset) begin
      charge_path <= '0;
    end else begin
      charge_path.enable <=
        (charge_cfg.charger_key == rtc_ctrl_pkg::CHARGER_KEY_ON) &&
        (charge_cfg.diode_select == rtc_ctrl_pkg::DIODE_NONE ||
         charge_cfg.diode_select == rtc_ctrl_pkg::DIODE_ONE) &&
        (charge_cfg.resistor_select != rtc_ctrl_pkg::RES_OFF);
      charge_path.one_diode <=
        (charge_cfg.diode_select == rtc_ctrl_pkg::DIODE_ONE);
      charge_path.resistor_select <= charge_cfg.resistor_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared output pin
  always_ff @(posedge clk) begin
    if (reset) begin
      backup_sync1 <= 1'b0;
      backup_sync2 <= 1'b0;
    end else begin
      backup_sync1 <= on_backup;
      backup_sync2 <= backup_sync1;
    end
  end

  // Interrupt follows the flags, so it holds until software clears them
  assign next_irq = control.interrupt_mode &
                    ((control.alarm_two_irq_enable & alarm_two_flag) |
                     (control.alarm_one_irq_enable & alarm_one_flag));

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_active <= 1'b0;
    end else begin
      irq_active <= next_irq;
    end
  end

  // Open drain: low drives, high releases; backup without enable floats
  assign pin_release = backup_sync2 & ~control.backup_output_enable;

  always_ff @(posedge clk) begin
    if (reset) begin
      wave_irq_oe_n <= 1'b1;
    end else if (pin_release) begin
      wave_irq_oe_n <= 1'b1;
    end else if (control.interrupt_mode) begin
      wave_irq_oe_n <= ~next_irq;
    end else begin
      wave_irq_oe_n <= wave;
    end
  end

  assign wave_irq_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata  <= rtc_ctrl_pkg::UNMAPPED_READ;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        if (hit(reg_addr, rtc_ctrl_pkg::ADDR_CONTROL)) begin
          reg_rdata <= control;
        end else if (hit(reg_addr, rtc_ctrl_pkg::ADDR_FLAGS)) begin
          reg_rdata <= {osc_stop_flag, 5'h00, alarm_two_flag,
                        alarm_one_flag};
        end else if (hit(reg_addr, rtc_ctrl_pkg::ADDR_CHARGE)) begin
          reg_rdata <= charge_cfg;
        end else begin
          reg_rdata <= rtc_ctrl_pkg::UNMAPPED_READ;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_halt_stops_osc: assert property (
    wr_control && reg_wdata[rtc_ctrl_pkg::CTRL_OSC_HALT_BIT]
    |=> !osc_enable)
    else $error("oscillator not halted by control write");

  a_backup_floats: assert property (
    $past(pin_release) |-> wave_irq_oe_n)
    else $error("pin driven on backup while disabled");

  a_wave_follows: assert property (
    !control.interrupt_mode && !pin_release && !$past(pin_release)
    && $stable(control.interrupt_mode) |=> wave_irq_oe_n == $past(wave))
    else $error("square wave not on shared pin");

  a_irq_mode_gate: assert property (
    !$past(control.interrupt_mode) |-> !irq_active)
    else $error("interrupt active outside interrupt mode");

  a_irq_or: assert property (
    irq_active == $past(control.interrupt_mode
      && ((control.alarm_one_irq_enable && alarm_one_flag)
      || (control.alarm_two_irq_enable && alarm_two_flag))))
    else $error("interrupt not OR of enabled flags");

  a_stop_sets: assert property (
    stop_event |=> osc_stop_flag)
    else $error("stop event did not set flag");

  a_stop_sticky: assert property (
    osc_stop_flag && !(wr_flags
      && !reg_wdata[rtc_ctrl_pkg::FLAG_OSC_STOP_BIT]) |=> osc_stop_flag)
    else $error("stop flag dropped without write zero");

  a_halt_flags: assert property (
    $rose(control.osc_halt) |-> ##[0:1] osc_stop_flag)
    else $error("halt did not set stop flag");

  a_alarm_sets: assert property (
    second_tick && alarm_one_match |=> alarm_one_flag)
    else $error("alarm one match lost");

  a_alarm_tick: assert property (
    $rose(alarm_one_flag) |-> $past(second_tick && alarm_one_match))
    else $error("alarm one flag set off the second tick");

  a_alarm2_clear: assert property (
    wr_flags && !reg_wdata[rtc_ctrl_pkg::FLAG_ALARM_TWO_BIT]
    && !(second_tick && alarm_two_match) |=> !alarm_two_flag)
    else $error("alarm two flag not cleared");

  a_key_gate: assert property (
    charge_cfg.charger_key != rtc_ctrl_pkg::CHARGER_KEY_ON
    |=> !charge_path.enable)
    else $error("charger enabled without key");

  a_diode_gate: assert property (
    charge_cfg.diode_select == 2'h0 || charge_cfg.diode_select == 2'h3
    |=> !charge_path.enable)
    else $error("charger enabled with bad diode code");

  a_rate_hold: assert property (
    $past(control.osc_halt) |-> $stable(wave))
    else $error("square wave moved while halted");

endmodule : rtc_control_status_trickle

//--- verif/osc_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Crystal oscillator seen by the block; stands still while halted
module osc_model (
  input  wire logic run,
  input  wire logic stall,
  input  wire logic fast,
  output logic      osc_clk
);
  // Fast mode only exists to reach a one-second tick in a short run;
  // its half period stays above one system clock so no level is missed
  initial begin
    osc_clk = 1'b0;
    // Offset keeps oscillator edges unrelated to the system clock
    #1.7;
    forever begin
      #(fast ? 8.3 : 40.0);
      if (run && !stall) begin
        osc_clk = ~osc_clk;
      end
    end
  end
endmodule : osc_model

//--- verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end

module tb_top;
  logic                       clk;
  logic                       reset;
  logic                       osc_clk;
  logic                       on_backup;
  logic                       a1_match;
  logic                       a2_match;
  logic [7:0]                 reg_addr;
  logic [7:0]                 reg_wdata;
  logic [7:0]                 reg_rdata;
  logic                       reg_write;
  logic                       reg_read;
  logic                       reg_rvalid;
  logic                       osc_enable;
  logic                       second_tick;
  logic                       wave_irq_out;
  logic                       wave_irq_oe_n;
  logic                       irq_active;
  logic                       stall;
  logic                       fast;
  rtc_ctrl_pkg::charge_path_t charge_path;
  int                         error_cnt;
  int                         tests_run;
  int                         cnt;
  logic [7:0] cv [10] = '{8'hA5, 8'hA9, 8'hA6, 8'hAA, 8'hA7, 8'hAB,
                          8'hA4, 8'hA1, 8'hAD, 8'h55};
  logic [3:0] ce [10] = '{4'h9, 4'hD, 4'hA, 4'hE, 4'hB, 4'hF,
                          4'h0, 4'h0, 4'h0, 4'h0};
  int         ex [4]  = '{0, 10, 20, 80};

  rtc_control_status_trickle #(.STOP_CYCLES(64)) DUT (
    .clk(clk), .reset(reset), .osc_clk(osc_clk), .on_backup(on_backup),
    .alarm_one_match(a1_match), .alarm_two_match(a2_match),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .osc_enable(osc_enable), .second_tick(second_tick),
    .wave_irq_out(wave_irq_out), .wave_irq_oe_n(wave_irq_oe_n),
    .irq_active(irq_active), .charge_path(charge_path)
  );

  osc_model PARTNER (
    .run(osc_enable), .stall(stall), .fast(fast), .osc_clk(osc_clk)
  );

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task results;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    @(negedge clk);
  endtask : wr

  task rdx(input logic [7:0] a, input logic [7:0] e,
           input logic [7:0] m = 8'hFF);
    int i;
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (i == 4) begin
      error_cnt++;
      results();
    end
    `CHK(reg_rdata & m, e)
    @(negedge clk);
  endtask : rdx

  task rises(input int n, output int c);
    logic p;
    c = 0;
    p = wave_irq_oe_n;
    repeat (n) begin
      @(negedge clk);
      if (wave_irq_oe_n === 1'b1 && p === 1'b0) c++;
      p = wave_irq_oe_n;
    end
  endtask : rises

  function automatic logic near(input int c, input int e);
    return (c >= e - 1) && (c <= e + 1);
  endfunction : near

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    rdx(8'h0E, 8'h18);
    rdx(8'h0F, 8'h80);
    rdx(8'h10, 8'h00);
    rdx(8'h11, 8'h00);
    `CHK(charge_path, 4'h0)
    `CHK(osc_enable, 1'b1)
    `CHK(wave_irq_out, 1'b0)
  endtask : t_reset

  task t_regs;
    wr(8'h0E, 8'hFF);
    rdx(8'h0E, 8'hBF);
    `CHK(osc_enable, 1'b0)
    cyc(100);
    wr(8'h0F, 8'hFF);
    rdx(8'h0F, 8'h80);
    wr(8'h0F, 8'h00);
    rdx(8'h0F, 8'h00);
    // Still halted: a level rather than an edge would set it again
    cyc(200);
    rdx(8'h0F, 8'h00);
    wr(8'h11, 8'h00);
    rdx(8'h0E, 8'hBF);
    wr(8'h0E, 8'h18);
  endtask : t_regs

  task t_charge;
    // The 250 ohm codes assume a supply below the limit
    for (int i = 0; i < 10; i++) begin
      wr(8'h10, cv[i]);
      cyc(2);
      rdx(8'h10, cv[i]);
      if (ce[i][3]) `CHK(charge_path, ce[i])
      else `CHK(charge_path.enable, 1'b0)
    end
    wr(8'h10, 8'h00);
  endtask : t_charge

  task t_wave;
    for (int r = 0; r < 4; r++) begin
      wr(8'h0E, {3'h0, r[1:0], 3'h0});
      cyc(4);
      rises(800, cnt);
      `CHK(near(cnt, ex[r]), 1'b1)
    end
    wr(8'h0E, 8'h98);
    cyc(4);
    rises(800, cnt);
    `CHK(cnt, 0)
    wr(8'h0E, 8'h18);
    on_backup = 1'b1;
    cyc(4);
    rises(800, cnt);
    `CHK(cnt, 0)
    `CHK(wave_irq_oe_n, 1'b1)
    wr(8'h0E, 8'h38);
    cyc(4);
    rises(800, cnt);
    `CHK(near(cnt, 80), 1'b1)
    on_backup = 1'b0;
    wr(8'h0E, 8'h04);
    cyc(4);
    rises(800, cnt);
    `CHK(cnt, 0)
  endtask : t_wave

  task t_osf;
    wr(8'h0E, 8'h18);
    cyc(20);
    wr(8'h0F, 8'h00);
    wr(8'h0E, 8'h98);
    rdx(8'h0F, 8'h80);
    wr(8'h0E, 8'h18);
    cyc(20);
    wr(8'h0F, 8'h00);
    stall = 1'b1;
    cyc(120);
    stall = 1'b0;
    cyc(20);
    rdx(8'h0F, 8'h80);
    wr(8'h0F, 8'h00);
    rdx(8'h0F, 8'h00);
  endtask : t_osf

  task t_alarm;
    int i;
    wr(8'h0E, 8'h04);
    a1_match = 1'b1;
    a2_match = 1'b1;
    cyc(100);
    rdx(8'h0F, 8'h00, 8'h03);
    fast = 1'b1;
    for (i = 0; i < 80000 && second_tick !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (i == 80000) begin
      error_cnt++;
      results();
    end
    @(negedge clk);
    a1_match = 1'b0;
    a2_match = 1'b0;
    cyc(2);
    rdx(8'h0F, 8'h03, 8'h03);
    `CHK(irq_active, 1'b0)
    wr(8'h0E, 8'h05);
    cyc(2);
    `CHK(irq_active, 1'b1)
    `CHK(wave_irq_oe_n, 1'b0)
    wr(8'h0E, 8'h01);
    cyc(2);
    `CHK(irq_active, 1'b0)
    wr(8'h0E, 8'h06);
    cyc(2);
    `CHK(irq_active, 1'b1)
    wr(8'h0E, 8'h07);
    wr(8'h0F, 8'h01);
    cyc(2);
    rdx(8'h0F, 8'h01, 8'h03);
    `CHK(irq_active, 1'b1)
    wr(8'h0F, 8'h02);
    cyc(2);
    rdx(8'h0F, 8'h00, 8'h03);
    `CHK(irq_active, 1'b0)
    `CHK(wave_irq_oe_n, 1'b1)
    fast = 1'b0;
  endtask : t_alarm

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    on_backup = 1'b0;
    a1_match = 1'b0;
    a2_match = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    stall = 1'b0;
    fast = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc(8);
    reset = 1'b0;
    t_reset();
    t_regs();
    t_charge();
    t_wave();
    t_osf();
    t_alarm();
    results();
  end
endmodule : tb_top
